// ### design/tcc_map.vh
// register offsets, field positions and constants of the 16-bit timer core
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

`define TCC_ADDR_W          4
`define TCC_OFS_CNT_LO      4'h0
`define TCC_OFS_CNT_HI      4'h1
`define TCC_OFS_CAP_LO      4'h2
`define TCC_OFS_CAP_HI      4'h3
`define TCC_OFS_CMPA_LO     4'h4
`define TCC_OFS_CMPA_HI     4'h5
`define TCC_OFS_CMPB_LO     4'h6
`define TCC_OFS_CMPB_HI     4'h7
`define TCC_OFS_CTRL_A      4'h8
`define TCC_OFS_CTRL_B      4'h9
`define TCC_OFS_FLAGS       4'ha
`define TCC_OFS_MASK        4'hb
`define TCC_OFS_CMP_CTRL    4'hc

// control a: waveform mode bits 1:0
`define TCC_CA_WGM_LO       1:0
// control b fields
`define TCC_CB_FILTER       7
`define TCC_CB_EDGE         6
`define TCC_CB_WGM_HI       4:3
`define TCC_CB_CS           2:0
// flags and mask bit positions
`define TCC_BIT_CAP         5
`define TCC_BIT_OVF         0
// comparator control: capture source select
`define TCC_BIT_ACSEL       2

// clock select codes
`define TCC_CS_STOP         3'h0
`define TCC_CS_DIV1         3'h1
`define TCC_CS_DIV8         3'h2
`define TCC_CS_DIV64        3'h3
`define TCC_CS_DIV256       3'h4
`define TCC_CS_DIV1024      3'h5
`define TCC_CS_EXT_FALL     3'h6
`define TCC_CS_EXT_RISE     3'h7
`define TCC_PRE_W           10
`define TCC_PRE_M8          10'h007
`define TCC_PRE_M64         10'h03f
`define TCC_PRE_M256        10'h0ff
`define TCC_PRE_M1024       10'h3ff

// counter values
`define TCC_BOTTOM          16'h0000
`define TCC_MAX             16'hffff
`define TCC_TOP8            16'h00ff
`define TCC_TOP9            16'h01ff
`define TCC_TOP10           16'h03ff

// waveform modes
`define TCC_WGM_NORMAL      4'h0
`define TCC_WGM_PC8         4'h1
`define TCC_WGM_PC9         4'h2
`define TCC_WGM_PC10        4'h3
`define TCC_WGM_CTC_A       4'h4
`define TCC_WGM_FAST8       4'h5
`define TCC_WGM_FAST9       4'h6
`define TCC_WGM_FAST10      4'h7
`define TCC_WGM_PFC_I       4'h8
`define TCC_WGM_PFC_A       4'h9
`define TCC_WGM_PC_I        4'ha
`define TCC_WGM_PC_A        4'hb
`define TCC_WGM_CTC_I       4'hc
`define TCC_WGM_RSVD        4'hd
`define TCC_WGM_FAST_I      4'he
`define TCC_WGM_FAST_A      4'hf

// filter depth in samples
`define TCC_FILT_N          4

`endif

// ### design/tcc_input_cond.v
// input synchroniser, optional majority-free noise filter and edge detector
`default_nettype none
`include "tcc_map.vh"

module tcc_input_cond #(
    parameter FILT_N = `TCC_FILT_N
) (
    input  wire sys_clk,
    input  wire reset,
    input  wire din,
    input  wire filt_en,
    output wire rise,
    output wire fall
);

    reg              sync1_ff;
    reg              sync2_ff;
    reg [FILT_N-1:0] samp_ff;
    reg              filt_ff;
    reg              level_ff;
    reg              prev_ff;
    reg              nxt_filt;
    reg              nxt_level;

    // ------------------------------------------------------------
    // filter: output follows only when all samples agree
    // ------------------------------------------------------------
    always @* begin
        nxt_filt = filt_ff;
        if (&samp_ff)
            nxt_filt = 1'b1;
        else if (~|samp_ff)
            nxt_filt = 1'b0;
        nxt_level = filt_en ? nxt_filt : sync2_ff;
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            samp_ff  <= {FILT_N{1'b0}};
            filt_ff  <= 1'b0;
            level_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= din;
            sync2_ff <= sync1_ff;
            samp_ff  <= {samp_ff[FILT_N-2:0], sync2_ff};
            filt_ff  <= nxt_filt;
            level_ff <= nxt_level;
            prev_ff  <= level_ff;
        end
    end

    assign rise = level_ff & ~prev_ff;
    assign fall = ~level_ff & prev_ff;

endmodule // tcc_input_cond
`default_nettype wire

// ### design/tcc_count_step.v
// next-count computation, top and bottom decoding for each waveform mode
`default_nettype none
`include "tcc_map.vh"

module tcc_count_step (
    input  wire [15:0] count,
    input  wire        dir_down,
    input  wire [3:0]  mode,
    input  wire [15:0] cmpa,
    input  wire [15:0] cap,
    output reg  [15:0] nxt_count,
    output reg         nxt_dir_down,
    output reg         at_top,
    output wire        at_bottom,
    output reg         ovf
);

    reg [15:0] top;
    reg        dual;
    reg        ctc;

    always @* begin
        dual = 1'b0;
        ctc  = 1'b0;
        case (mode)
            `TCC_WGM_PC8:    begin top = `TCC_TOP8;  dual = 1'b1; end
            `TCC_WGM_PC9:    begin top = `TCC_TOP9;  dual = 1'b1; end
            `TCC_WGM_PC10:   begin top = `TCC_TOP10; dual = 1'b1; end
            `TCC_WGM_CTC_A:  begin top = cmpa;       ctc  = 1'b1; end
            `TCC_WGM_FAST8:  top = `TCC_TOP8;
            `TCC_WGM_FAST9:  top = `TCC_TOP9;
            `TCC_WGM_FAST10: top = `TCC_TOP10;
            `TCC_WGM_PFC_I:  begin top = cap;        dual = 1'b1; end
            `TCC_WGM_PFC_A:  begin top = cmpa;       dual = 1'b1; end
            `TCC_WGM_PC_I:   begin top = cap;        dual = 1'b1; end
            `TCC_WGM_PC_A:   begin top = cmpa;       dual = 1'b1; end
            `TCC_WGM_CTC_I:  begin top = cap;        ctc  = 1'b1; end
            `TCC_WGM_FAST_I: top = cap;
            `TCC_WGM_FAST_A: top = cmpa;
            default:         top = `TCC_MAX;
        endcase
        at_top       = (count == top);
        nxt_dir_down = dir_down;
        ovf          = 1'b0;
        if (dual) begin
            if (!dir_down && at_top)
                nxt_dir_down = 1'b1;
            else if (dir_down && at_bottom)
                nxt_dir_down = 1'b0;
            nxt_count = nxt_dir_down ? count - 16'h0001 : count + 16'h0001;
            ovf       = dir_down && at_bottom;
        end else begin
            nxt_dir_down = 1'b0;
            nxt_count    = at_top ? `TCC_BOTTOM : count + 16'h0001;
            ovf          = ctc ? (count == `TCC_MAX) : at_top;
        end
    end

    assign at_bottom = (count == `TCC_BOTTOM);

endmodule // tcc_count_step
`default_nettype wire

// ### design/tcc_timer16.v
// 16-bit timer/counter core with input capture and byte-wide register access
`default_nettype none
`include "tcc_map.vh"

// How it works
// - clock select zero stops the counter
// - tick clears, increments or decrements count
// - top and bottom flags; clear zeroes
// - upper byte through shared staging register
// - count accessible with or without ticks
// - cpu write beats clear or count
// - mode field picks sequence and overflow
// - matching capture edge copies count
// - capture flag set with copy, raises irq
// - flag cleared by service or one-write
// - capture read low first via staging
// - capture writable only in its top modes
// - comparator select reroutes capture source
// - filter adds four cycles latency
// - filter needs four equal samples
// - no capture in capture-top modes
// - new capture overwrites old value
// - pin driven by port triggers capture
// - bottom, max and top values
// - compare reads bypass staging register
module tcc_timer16 (
    input  wire                   sys_clk,
    input  wire                   reset,
    input  wire [`TCC_ADDR_W-1:0] bus_addr,
    input  wire                   bus_wr,
    input  wire                   bus_rd,
    input  wire [7:0]             bus_wdata,
    output wire [7:0]             bus_rdata,
    input  wire                   capture_input_pin,
    input  wire                   comparator_output,
    input  wire                   external_count_pin,
    input  wire                   capture_irq_ack,
    input  wire                   overflow_irq_ack,
    output wire                   capture_irq,
    output wire                   overflow_irq,
    output wire                   at_top,
    output wire                   at_bottom
);

    reg  [15:0]          count_value_ff;
    reg                  dir_down_ff;
    reg  [15:0]          capture_value_ff;
    reg  [15:0]          cmpa_ff;
    reg  [15:0]          cmpb_ff;
    reg  [7:0]           staging_ff;
    reg  [7:0]           timer_control_a_ff;
    reg  [7:0]           timer_control_b_ff;
    reg                  comparator_capture_select_ff;
    reg                  capture_flag_ff;
    reg                  overflow_flag_ff;
    reg                  capture_irq_enable_ff;
    reg                  overflow_irq_enable_ff;
    reg  [`TCC_PRE_W-1:0] presc_ff;
    reg  [7:0]           rdata_ff;
    reg                  capture_irq_ff;
    reg                  overflow_irq_ff;
    reg                  at_top_ff;
    reg                  at_bottom_ff;

    reg  [15:0]          nxt_count_value;
    reg                  nxt_dir_down;
    reg  [15:0]          nxt_capture_value;
    reg  [15:0]          nxt_cmpa;
    reg  [15:0]          nxt_cmpb;
    reg  [7:0]           nxt_staging;
    reg  [7:0]           nxt_rdata;
    reg                  nxt_capture_flag;
    reg                  nxt_overflow_flag;
    reg                  timer_tick;

    wire [3:0]           waveform_mode_field;
    wire [2:0]           clock_select_field;
    wire                 filter_enable;
    wire                 edge_select;
    wire                 cap_src;
    wire                 cap_rise;
    wire                 cap_fall;
    wire                 ext_rise;
    wire                 ext_fall;
    wire [15:0]          step_count;
    wire                 step_dir_down;
    wire                 step_top;
    wire                 step_bottom;
    wire                 step_ovf;
    wire                 capture_event;
    wire                 wr_cnt_lo;
    wire                 flags_wr;

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    function cap_is_top;
        input [3:0] mode;
        begin
            cap_is_top = (mode == `TCC_WGM_PFC_I) || (mode == `TCC_WGM_PC_I) ||
                         (mode == `TCC_WGM_CTC_I) || (mode == `TCC_WGM_FAST_I);
        end
    endfunction

    assign waveform_mode_field = {timer_control_b_ff[`TCC_CB_WGM_HI],
                                  timer_control_a_ff[`TCC_CA_WGM_LO]};
    assign clock_select_field  = timer_control_b_ff[`TCC_CB_CS];
    assign filter_enable       = timer_control_b_ff[`TCC_CB_FILTER];
    assign edge_select         = timer_control_b_ff[`TCC_CB_EDGE];

    // ------------------------------------------------------------
    // capture source and conditioning
    // ------------------------------------------------------------
    // the pin level already reflects any port drive, so software can
    // provoke a capture simply by toggling that pin
    assign cap_src = comparator_capture_select_ff ? comparator_output
                                                  : capture_input_pin;

    tcc_input_cond u_cap_cond (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     (cap_src),
        .filt_en (filter_enable),
        .rise    (cap_rise),
        .fall    (cap_fall)
    );

    tcc_input_cond u_ext_cond (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     (external_count_pin),
        .filt_en (1'b0),
        .rise    (ext_rise),
        .fall    (ext_fall)
    );

    assign capture_event = (edge_select ? cap_rise : cap_fall) &&
                           !cap_is_top(waveform_mode_field);

    // ------------------------------------------------------------
    // timer tick selection
    // ------------------------------------------------------------
    always @* begin
        case (clock_select_field)
            `TCC_CS_STOP:     timer_tick = 1'b0;
            `TCC_CS_DIV1:     timer_tick = 1'b1;
            `TCC_CS_DIV8:     timer_tick = (presc_ff & `TCC_PRE_M8) == `TCC_PRE_M8;
            `TCC_CS_DIV64:    timer_tick = (presc_ff & `TCC_PRE_M64) == `TCC_PRE_M64;
            `TCC_CS_DIV256:   timer_tick = (presc_ff & `TCC_PRE_M256) == `TCC_PRE_M256;
            `TCC_CS_DIV1024:  timer_tick = presc_ff == `TCC_PRE_M1024;
            `TCC_CS_EXT_FALL: timer_tick = ext_fall;
            `TCC_CS_EXT_RISE: timer_tick = ext_rise;
            default:          timer_tick = 1'b0;
        endcase
    end

    tcc_count_step u_step (
        .count        (count_value_ff),
        .dir_down     (dir_down_ff),
        .mode         (waveform_mode_field),
        .cmpa         (cmpa_ff),
        .cap          (capture_value_ff),
        .nxt_count    (step_count),
        .nxt_dir_down (step_dir_down),
        .at_top       (step_top),
        .at_bottom    (step_bottom),
        .ovf          (step_ovf)
    );

    // ------------------------------------------------------------
    // register access and state update
    // ------------------------------------------------------------
    assign wr_cnt_lo = bus_wr && (bus_addr == `TCC_OFS_CNT_LO);
    assign flags_wr  = bus_wr && (bus_addr == `TCC_OFS_FLAGS);

    always @* begin
        nxt_count_value   = count_value_ff;
        nxt_dir_down      = dir_down_ff;
        nxt_capture_value = capture_value_ff;
        nxt_cmpa          = cmpa_ff;
        nxt_cmpb          = cmpb_ff;
        nxt_staging       = staging_ff;
        nxt_rdata         = 8'h00;
        if (timer_tick) begin
            nxt_count_value = step_count;
            nxt_dir_down    = step_dir_down;
        end
        if (wr_cnt_lo)
            nxt_count_value = {staging_ff, bus_wdata};
        if (capture_event)
            nxt_capture_value = count_value_ff;
        if (bus_wr) begin
            case (bus_addr)
                `TCC_OFS_CNT_HI,
                `TCC_OFS_CAP_HI,
                `TCC_OFS_CMPA_HI,
                `TCC_OFS_CMPB_HI: nxt_staging = bus_wdata;
                `TCC_OFS_CAP_LO: begin
                    if (cap_is_top(waveform_mode_field))
                        nxt_capture_value = {staging_ff, bus_wdata};
                end
                `TCC_OFS_CMPA_LO: nxt_cmpa = {staging_ff, bus_wdata};
                `TCC_OFS_CMPB_LO: nxt_cmpb = {staging_ff, bus_wdata};
                default: ;
            endcase
        end
        if (bus_rd) begin
            case (bus_addr)
                `TCC_OFS_CNT_LO: begin
                    nxt_rdata   = count_value_ff[7:0];
                    nxt_staging = count_value_ff[15:8];
                end
                `TCC_OFS_CNT_HI:   nxt_rdata = staging_ff;
                `TCC_OFS_CAP_LO: begin
                    nxt_rdata   = capture_value_ff[7:0];
                    nxt_staging = capture_value_ff[15:8];
                end
                `TCC_OFS_CAP_HI:   nxt_rdata = staging_ff;
                `TCC_OFS_CMPA_LO:  nxt_rdata = cmpa_ff[7:0];
                `TCC_OFS_CMPA_HI:  nxt_rdata = cmpa_ff[15:8];
                `TCC_OFS_CMPB_LO:  nxt_rdata = cmpb_ff[7:0];
                `TCC_OFS_CMPB_HI:  nxt_rdata = cmpb_ff[15:8];
                `TCC_OFS_CTRL_A:   nxt_rdata = timer_control_a_ff;
                `TCC_OFS_CTRL_B:   nxt_rdata = timer_control_b_ff;
                `TCC_OFS_FLAGS: begin
                    nxt_rdata[`TCC_BIT_CAP] = capture_flag_ff;
                    nxt_rdata[`TCC_BIT_OVF] = overflow_flag_ff;
                end
                `TCC_OFS_MASK: begin
                    nxt_rdata[`TCC_BIT_CAP] = capture_irq_enable_ff;
                    nxt_rdata[`TCC_BIT_OVF] = overflow_irq_enable_ff;
                end
                `TCC_OFS_CMP_CTRL: nxt_rdata[`TCC_BIT_ACSEL] = comparator_capture_select_ff;
                default:           nxt_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // flags: a set in the clearing cycle wins
    // ------------------------------------------------------------
    always @* begin
        nxt_capture_flag  = capture_flag_ff;
        nxt_overflow_flag = overflow_flag_ff;
        if (capture_irq_ack || (flags_wr && bus_wdata[`TCC_BIT_CAP]))
            nxt_capture_flag = 1'b0;
        if (overflow_irq_ack || (flags_wr && bus_wdata[`TCC_BIT_OVF]))
            nxt_overflow_flag = 1'b0;
        if (capture_event)
            nxt_capture_flag = 1'b1;
        if (timer_tick && step_ovf && !wr_cnt_lo)
            nxt_overflow_flag = 1'b1;
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_value_ff               <= `TCC_BOTTOM;
            dir_down_ff                  <= 1'b0;
            capture_value_ff             <= `TCC_BOTTOM;
            cmpa_ff                      <= `TCC_BOTTOM;
            cmpb_ff                      <= `TCC_BOTTOM;
            staging_ff                   <= 8'h00;
            timer_control_a_ff           <= 8'h00;
            timer_control_b_ff           <= 8'h00;
            comparator_capture_select_ff <= 1'b0;
            capture_flag_ff              <= 1'b0;
            overflow_flag_ff             <= 1'b0;
            capture_irq_enable_ff        <= 1'b0;
            overflow_irq_enable_ff       <= 1'b0;
            presc_ff                     <= {`TCC_PRE_W{1'b0}};
            rdata_ff                     <= 8'h00;
            capture_irq_ff               <= 1'b0;
            overflow_irq_ff              <= 1'b0;
            at_top_ff                    <= 1'b0;
            at_bottom_ff                 <= 1'b1;
        end else begin
            count_value_ff   <= nxt_count_value;
            dir_down_ff      <= nxt_dir_down;
            capture_value_ff <= nxt_capture_value;
            cmpa_ff          <= nxt_cmpa;
            cmpb_ff          <= nxt_cmpb;
            staging_ff       <= nxt_staging;
            capture_flag_ff  <= nxt_capture_flag;
            overflow_flag_ff <= nxt_overflow_flag;
            presc_ff         <= presc_ff + {{(`TCC_PRE_W-1){1'b0}}, 1'b1};
            rdata_ff         <= nxt_rdata;
            if (bus_wr && bus_addr == `TCC_OFS_CTRL_A)
                timer_control_a_ff <= bus_wdata;
            if (bus_wr && bus_addr == `TCC_OFS_CTRL_B)
                timer_control_b_ff <= bus_wdata;
            if (bus_wr && bus_addr == `TCC_OFS_CMP_CTRL)
                comparator_capture_select_ff <= bus_wdata[`TCC_BIT_ACSEL];
            if (bus_wr && bus_addr == `TCC_OFS_MASK) begin
                capture_irq_enable_ff  <= bus_wdata[`TCC_BIT_CAP];
                overflow_irq_enable_ff <= bus_wdata[`TCC_BIT_OVF];
            end
            capture_irq_ff  <= nxt_capture_flag && capture_irq_enable_ff;
            overflow_irq_ff <= nxt_overflow_flag && overflow_irq_enable_ff;
            at_top_ff       <= step_top;
            at_bottom_ff    <= step_bottom;
        end
    end

    assign bus_rdata    = rdata_ff;
    assign capture_irq  = capture_irq_ff;
    assign overflow_irq = overflow_irq_ff;
    assign at_top       = at_top_ff;
    assign at_bottom    = at_bottom_ff;

endmodule // tcc_timer16
`default_nettype wire

// ### bench/tcc_timer16_chk.sv
// port-level assertions for the timer core
`default_nettype none
module tcc_timer16_chk (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic [3:0] bus_addr,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic       capture_input_pin,
    input wire logic       comparator_output,
    input wire logic       capture_irq_ack,
    input wire logic       capture_irq,
    input wire logic       at_bottom
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] q_ff;
    logic       quiet;
    // cycles since anything that may start a capture
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset)
            q_ff <= 4'h0;
        else if ($changed(capture_input_pin) || $changed(comparator_output)
                 || (bus_wr && (bus_addr == 4'h9 || bus_addr > 4'ha)))
            q_ff <= 4'h0;
        else if (q_ff != 4'hf)
            q_ff <= q_ff + 4'h1;
    end
    assign quiet = (q_ff >= 4'hc);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_RD_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not idle");
    AST_UNMAP: assert property (bus_rd && bus_addr > 4'hc |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_STAGE: assert property ((bus_wr && bus_addr == 4'h1) ##1 (bus_rd && bus_addr == 4'h1)
        |=> bus_rdata == $past(bus_wdata, 2)) else $error("count high not staging");
    AST_SHARE: assert property ((bus_wr && bus_addr == 4'h5) ##1 (bus_rd && bus_addr == 4'h3)
        |=> bus_rdata == $past(bus_wdata, 2)) else $error("staging not shared");
    AST_BOTTOM: assert property ((bus_wr && bus_addr == 4'h1 && bus_wdata == 8'h00) ##1
        (bus_wr && bus_addr == 4'h0 && bus_wdata == 8'h00) |-> ##[1:3] at_bottom)
        else $error("bottom missing after zero write");
    AST_ACK: assert property (quiet && capture_irq_ack |-> ##[1:2] !capture_irq)
        else $error("ack did not clear capture");
    AST_W1C: assert property (quiet && bus_wr && bus_addr == 4'ha && bus_wdata[5]
        |-> ##[1:2] !capture_irq) else $error("one-write did not clear capture");
    AST_QUIET: assert property (quiet && !capture_irq |=> !capture_irq)
        else $error("capture without event");
    cover property ($rose(capture_irq));
    cover property ($rose(at_bottom));
    cover property (quiet && capture_irq_ack);
endmodule // tcc_timer16_chk
bind tcc_timer16 tcc_timer16_chk chk_u (.sys_clk(sys_clk), .reset(reset),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .capture_input_pin(capture_input_pin),
    .comparator_output(comparator_output), .capture_irq_ack(capture_irq_ack),
    .capture_irq(capture_irq), .at_bottom(at_bottom));
`default_nettype wire

// ### bench/tcc_cpu_model.sv
// host cpu model on the byte-wide register bus
`default_nettype none
module tcc_cpu_model (
    input  wire logic       sys_clk,
    output var  logic [3:0] bus_addr,
    output var  logic       bus_wr,
    output var  logic       bus_rd,
    output var  logic [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rq;
    initial begin
        bus_addr = 4'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end
    always @(negedge sys_clk) rq <= bus_rdata;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        bus_rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic idle();
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        bus_wdata <= ~bus_wdata;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus_addr <= a;
        bus_wr <= 1'b0;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        idle();
        d = rq;
    endtask
    task automatic w16(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
        idle();
    endtask
    task automatic wlo(input logic [3:0] a, input logic [7:0] d);
        wr(a, d);
        idle();
    endtask
    task automatic r16(input logic [3:0] a, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + 4'h1, hi);
        v = {hi, lo};
    endtask
endmodule // tcc_cpu_model
`default_nettype wire

// ### bench/tcc_timer16_tb_top.sv
// self-checking bench for the timer core
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module tcc_timer16_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk, reset, pin, cmp, ack_c, ack_o, cap_irq, ovf_irq, top, bot, wr, rd;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, b;
    logic [15:0] v;
    int         fails, n_tests;
    tcc_timer16 dut_u (.sys_clk(sys_clk), .reset(reset), .bus_addr(addr), .bus_wr(wr),
        .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata), .capture_input_pin(pin),
        .comparator_output(cmp), .external_count_pin(1'b0), .capture_irq_ack(ack_c),
        .overflow_irq_ack(ack_o), .capture_irq(cap_irq), .overflow_irq(ovf_irq),
        .at_top(top), .at_bottom(bot));
    tcc_cpu_model cpu_u (.sys_clk(sys_clk), .bus_addr(addr), .bus_wr(wr), .bus_rd(rd),
        .bus_wdata(wdata), .bus_rdata(rdata));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // ------
    // scenarios
    // ------
    task automatic t_count();
        cpu_u.w16(4'h0, 16'h12ab);
        cyc(3);
        cpu_u.r16(4'h0, v);
        `CHK(v, 16'h12ab)
        cpu_u.wr(4'h9, 8'h01);
        cpu_u.wr(4'h9, 8'h00);
        cpu_u.idle();
        cpu_u.r16(4'h0, v);
        `CHK(v, 16'h12ac)
        cpu_u.wr(4'h9, 8'h01);
        cpu_u.w16(4'h0, 16'h4000);
        cpu_u.wr(4'h9, 8'h00);
        cpu_u.r16(4'h0, v);
        `CHK(v, 16'h4002)
        $display("t_count done");
    endtask
    task automatic t_edge();
        cpu_u.wr(4'h8, 8'h01);
        cpu_u.wr(4'h9, 8'h08);
        cpu_u.w16(4'h0, 16'h00ff);
        cyc(2);
        `CHK(top, 1'b1)
        cpu_u.wr(4'h8, 8'h00);
        cpu_u.wr(4'h9, 8'h00);
        cpu_u.w16(4'h0, 16'h0000);
        cyc(2);
        `CHK(bot, 1'b1)
        cpu_u.wr(4'hb, 8'h01);
        cpu_u.w16(4'h0, 16'hffff);
        cpu_u.wr(4'h9, 8'h01);
        cpu_u.wr(4'h9, 8'h00);
        cpu_u.idle();
        cyc(2);
        `CHK(ovf_irq, 1'b1)
        cpu_u.r16(4'h0, v);
        `CHK(v, 16'h0000)
        $display("t_edge done");
    endtask
    task automatic t_stage();
        cpu_u.w16(4'h4, 16'ha55a);
        cpu_u.wlo(4'h6, 8'h11);
        cpu_u.wr(4'h1, 8'h3c);
        cpu_u.rd(4'h7, b);
        `CHK(b, 8'ha5)
        cpu_u.rd(4'h1, b);
        `CHK(b, 8'h3c)
        cpu_u.wr(4'h5, 8'h77);
        cpu_u.rd(4'h3, b);
        `CHK(b, 8'h77)
        cpu_u.wr(4'h1, 8'h5e);
        cpu_u.rd(4'h1, b);
        `CHK(b, 8'h5e)
        cpu_u.rd(4'hd, b);
        `CHK(b, 8'h00)
        $display("t_stage done");
    endtask
    task automatic t_cap();
        cpu_u.w16(4'h0, 16'h0100);
        cpu_u.wr(4'hb, 8'h20);
        cpu_u.wr(4'h9, 8'h40);
        cpu_u.idle();
        pin <= 1'b1;
        cyc(14);
        `CHK(cap_irq, 1'b1)
        cpu_u.r16(4'h2, v);
        `CHK(v, 16'h0100)
        cpu_u.w16(4'h0, 16'h0200);
        pin <= 1'b0;
        cyc(14);
        pin <= 1'b1;
        cyc(14);
        cpu_u.r16(4'h2, v);
        `CHK(v, 16'h0200)
        cpu_u.wlo(4'ha, 8'h00);
        `CHK(cap_irq, 1'b1)
        ack_c <= 1'b1;
        cyc(1);
        ack_c <= 1'b0;
        cyc(2);
        `CHK(cap_irq, 1'b0)
        cpu_u.wlo(4'h9, 8'h00);
        cpu_u.w16(4'h0, 16'h0300);
        pin <= 1'b0;
        cyc(14);
        cpu_u.r16(4'h2, v);
        `CHK(v, 16'h0300)
        cpu_u.wr(4'h9, 8'h40);
        cpu_u.wlo(4'ha, 8'h20);
        cyc(2);
        `CHK(cap_irq, 1'b0)
        $display("t_cap done");
    endtask
    task automatic t_filt();
        cpu_u.wlo(4'h9, 8'hc0);
        pin <= 1'b1;
        cyc(2);
        pin <= 1'b0;
        cyc(14);
        `CHK(cap_irq, 1'b0)
        pin <= 1'b1;
        cyc(7);
        @(negedge sys_clk) `CHK(cap_irq, 1'b0)
        @(negedge sys_clk) `CHK(cap_irq, 1'b1)
        cyc(1);
        cpu_u.wlo(4'hc, 8'h04);
        cyc(14);
        cpu_u.wlo(4'ha, 8'h20);
        cmp <= 1'b1;
        cyc(14);
        `CHK(cap_irq, 1'b1)
        cpu_u.wlo(4'ha, 8'h20);
        cpu_u.wr(4'hc, 8'h00);
        cpu_u.wr(4'h9, 8'h58);
        cpu_u.w16(4'h2, 16'h1234);
        pin <= 1'b0;
        cyc(14);
        pin <= 1'b1;
        cyc(14);
        `CHK(cap_irq, 1'b0)
        cpu_u.r16(4'h2, v);
        `CHK(v, 16'h1234)
        cpu_u.wr(4'h9, 8'h00);
        cpu_u.w16(4'h2, 16'h5555);
        cpu_u.r16(4'h2, v);
        `CHK(v, 16'h1234)
        $display("t_filt done");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // tests need about 280 cycles
    initial begin
        #500us;
        fails++;
        close_out();
    end
    initial begin
        {reset, pin, cmp, ack_c, ack_o} = 5'h10;
        cyc(5);
        reset <= 1'b0;
        cyc(1);
        t_count();
        t_edge();
        t_stage();
        t_cap();
        t_filt();
        close_out();
    end
endmodule // tcc_timer16_tb_top
`default_nettype wire
